// >>> irb_intc.sv
/*
  Interrupt acceptance and entry sequencer with address-break source.
  Assumes the CPU core reports instruction ends, condition-code instructions and
  block-move progress as one-cycle pulses or levels on the same clock; external
  request, key and non-maskable pins are asynchronous and active low.
*/
module irb_intc #(
  parameter int unsigned NUM_INT = 8
) (
  input  wire logic                         mclk_i,
  input  wire logic                         arst_n_i,
  // cpu progress
  input  wire logic                         insn_end_i,
  input  wire logic                         ccr_insn_end_i,
  input  wire logic                         ccr_i_bit_i,
  input  wire logic                         ccr_ui_bit_i,
  input  wire logic                         blk_byte_busy_i,
  input  wire logic                         blk_word_busy_i,
  input  wire logic                         blk_word_gap_i,
  input  wire logic                         normal_mode_i,
  input  wire logic                         prefetch_i,
  input  wire logic [irb_pkg::ADDR_W-1:0]   fetch_addr_i,
  // break control
  input  wire logic                         bar_wr_i,
  input  wire logic [irb_pkg::ADDR_W-1:0]   bar_data_i,
  input  wire logic                         bie_wr_i,
  input  wire logic                         bie_data_i,
  input  wire logic                         cmf_clr_i,
  // sources
  input  wire logic                         nmi_n_i,
  input  wire logic [irb_pkg::NUM_EXT-1:0]  ext_irq_n_i,
  input  wire logic [irb_pkg::NUM_EXT-1:0]  ext_en_i,
  input  wire logic [irb_pkg::NUM_EXT-1:0]  ext_flag_clr_i,
  input  wire logic                         key_n_i,
  input  wire logic                         key_en_i,
  input  wire logic                         key_flag_clr_i,
  input  wire logic                         vec_mode_i,
  input  wire logic [NUM_INT-1:0]           int_req_i,
  input  wire logic [NUM_INT-1:0]           int_en_i,
  // results
  output logic [irb_pkg::ADDR_W-1:0]        bar_o,
  output logic                              bie_o,
  output logic                              cmf_o,
  output logic [irb_pkg::NUM_EXT-1:0]       ext_flag_o,
  output logic                              key_flag_o,
  output logic                              i_mask_o,
  output logic                              ui_mask_o,
  output logic [3:0]                        state_o,
  output logic                              accept_o,
  output logic [4:0]                        src_o,
  output logic                              save_next_pc_o,
  output logic [4:0]                        wait_states_o,
  output logic                              handler_start_o
);
  import irb_pkg::*;

  localparam int unsigned NSRC = IDX_INT0 + NUM_INT;

  // elaboration check: every source index must stay below the none code
  if (NUM_INT < 1 || NSRC > 31) begin : g_bad_num_int
    $error("irb_intc: NUM_INT out of range");
  end

  // lowest set index wins the fixed default order
  function automatic logic [4:0] pick(input logic [NSRC-1:0] req);
    logic [4:0] w;
    w = SRC_NONE;
    for (int k = NSRC - 1; k >= 0; k--) begin
      if (req[k]) begin
        w = 5'(k);
      end
    end
    return w;
  endfunction

  function automatic logic [4:0] prio_len(input logic [4:0] s);
    logic internal;
    internal = (s == 5'(IDX_BRK)) || (s >= 5'(IDX_INT0));
    return internal ? PRIO_INT_ST : PRIO_EXT_ST;
  endfunction

  irb_state_t                state_q;
  logic [4:0]                cnt_q;
  logic [4:0]                src_q;
  logic                      accept_q;
  logic                      save_next_q;
  logic [4:0]                wait_q;
  logic                      start_q;
  logic [NUM_EXT+1:0]        sync1_q;
  logic [NUM_EXT+1:0]        sync2_q;
  logic [NUM_EXT+1:0]        prev_q;
  logic [NUM_EXT-1:0]        ext_flag_q;
  logic                      key_flag_q;
  logic [NUM_EXT-1:0]        ext_en_q;
  logic                      key_en_q;
  logic [NUM_INT-1:0]        int_en_q;
  logic                      nmi_pend_q;
  logic                      brk_pend_q;
  logic                      holdoff_q;
  logic [MASK_DLY_ST-1:0]    i_pipe_q;
  logic [MASK_DLY_ST-1:0]    ui_pipe_q;
  logic                      i_mask_q;
  logic                      ui_mask_q;
  logic                      brk_req;
  logic [NUM_EXT+1:0]        seen;
  logic [NSRC-1:0]           req_vec;
  logic [4:0]                winner;
  logic                      accept_ok;
  logic                      nmi_fall;

  irb_brk_cmp u_brk (
    .mclk_i        (mclk_i),
    .arst_n_i      (arst_n_i),
    .bar_wr_i      (bar_wr_i),
    .bar_data_i    (bar_data_i),
    .bie_wr_i      (bie_wr_i),
    .bie_data_i    (bie_data_i),
    .cmf_clr_i     (cmf_clr_i),
    .normal_mode_i (normal_mode_i),
    .prefetch_i    (prefetch_i),
    .fetch_addr_i  (fetch_addr_i),
    .bar_o         (bar_o),
    .bie_o         (bie_o),
    .cmf_o         (cmf_o),
    .brk_req_o     (brk_req)
  );

  // pin synchronisers; reset high so a pin held low after reset reads as a falling edge
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_q <= '1;
      sync2_q <= '1;
      prev_q  <= '1;
    end else begin
      sync1_q <= {nmi_n_i, key_n_i, ext_irq_n_i};
      sync2_q <= sync1_q;
      prev_q  <= seen;
    end
  end

  // key level is only observed in the extended vector mode
  assign seen     = {sync2_q[NUM_EXT+1], sync2_q[NUM_EXT] | ~vec_mode_i, sync2_q[NUM_EXT-1:0]};
  assign nmi_fall = prev_q[NUM_EXT+1] & ~seen[NUM_EXT+1];

  // external request flags, falling edge sets, software zero clears, set wins
  generate
    for (genvar g = 0; g < NUM_EXT; g++) begin : g_ext
      always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          ext_flag_q[g] <= 1'b0;
        end else if (prev_q[g] && !seen[g]) begin
          ext_flag_q[g] <= 1'b1;
        end else if (ext_flag_clr_i[g]) begin
          ext_flag_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // key flag, non-maskable and break pending bits
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      key_flag_q <= 1'b0;
      nmi_pend_q <= 1'b0;
      brk_pend_q <= 1'b0;
    end else begin
      if (prev_q[NUM_EXT] && !seen[NUM_EXT]) begin
        key_flag_q <= 1'b1;
      end else if (key_flag_clr_i) begin
        key_flag_q <= 1'b0;
      end
      if (nmi_fall) begin
        nmi_pend_q <= 1'b1;
      end else if (accept_q && src_q == 5'(IDX_NMI)) begin
        nmi_pend_q <= 1'b0;
      end
      if (brk_req) begin
        brk_pend_q <= 1'b1;
      end else if (accept_q && src_q == 5'(IDX_BRK)) begin
        brk_pend_q <= 1'b0;
      end
    end
  end

  // enables are sampled at instruction ends so a clear lands after its instruction
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ext_en_q <= '0;
      key_en_q <= 1'b0;
      int_en_q <= '0;
    end else if (insn_end_i) begin
      ext_en_q <= ext_en_i;
      key_en_q <= key_en_i;
      int_en_q <= int_en_i;
    end
  end

  // mask bits delayed two states after a condition-code instruction, plus one-insn holdoff
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      i_pipe_q  <= '0;
      ui_pipe_q <= '0;
      i_mask_q  <= 1'b0;
      ui_mask_q <= 1'b0;
      holdoff_q <= 1'b0;
    end else begin
      i_pipe_q  <= {i_pipe_q[MASK_DLY_ST-2:0], ccr_insn_end_i};
      ui_pipe_q <= {ui_pipe_q[MASK_DLY_ST-2:0], ccr_insn_end_i};
      if (i_pipe_q[MASK_DLY_ST-1]) begin
        i_mask_q <= ccr_i_bit_i;
      end else if (start_q) begin
        i_mask_q <= 1'b1;
      end
      if (ui_pipe_q[MASK_DLY_ST-1]) begin
        ui_mask_q <= ccr_ui_bit_i;
      end
      if (ccr_insn_end_i) begin
        holdoff_q <= 1'b1;
      end else if (insn_end_i) begin
        holdoff_q <= 1'b0;
      end
    end
  end

  // request vector; maskable sources gated by their enables and the interrupt mask, never by ui_mask_q
  assign req_vec   = {int_req_i & int_en_q & {NUM_INT{~i_mask_q}},
                      key_flag_q & key_en_q & ~i_mask_q,
                      ext_flag_q & ext_en_q & {NUM_EXT{~i_mask_q}},
                      brk_pend_q,
                      nmi_pend_q};
  assign winner    = pick(req_vec);
  assign accept_ok = !holdoff_q && !ccr_insn_end_i && !blk_byte_busy_i
                   && (!blk_word_busy_i || blk_word_gap_i);

  // entry sequencer
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q     <= IRB_IDLE;
      cnt_q       <= 5'h00;
      src_q       <= SRC_NONE;
      accept_q    <= 1'b0;
      save_next_q <= 1'b0;
      wait_q      <= 5'h00;
      start_q     <= 1'b0;
    end else begin
      accept_q <= 1'b0;
      start_q  <= 1'b0;
      unique case (state_q)
        IRB_IDLE: begin
          if (winner != SRC_NONE) begin
            state_q <= IRB_PRIO;
            cnt_q   <= prio_len(winner) - 5'h01;
          end
        end
        IRB_PRIO: begin
          if (cnt_q != 5'h00) begin
            cnt_q <= cnt_q - 5'h01;
          end else if (winner == SRC_NONE) begin
            state_q <= IRB_IDLE;         // cleared source dropped
          end else if (accept_ok) begin
            state_q     <= IRB_WAIT;
            src_q       <= winner;
            accept_q    <= 1'b1;
            save_next_q <= blk_word_busy_i;
            wait_q      <= 5'h01;
          end
        end
        IRB_WAIT: begin
          if (insn_end_i || blk_word_gap_i) begin
            state_q <= IRB_FETCH1;
            cnt_q   <= HALF_ST - 5'h01;
          end else if (wait_q != WAIT_MAX_ST) begin
            wait_q <= wait_q + 5'h01;
          end
        end
        IRB_FETCH1, IRB_INT1, IRB_STACK, IRB_VECTOR, IRB_INT2: begin
          if (cnt_q != 5'h00) begin
            cnt_q <= cnt_q - 5'h01;
          end else begin
            state_q <= irb_state_t'(state_q + 4'h1);
            unique case (state_q)
              IRB_INT1:   cnt_q <= STACK_ST - 5'h01;
              IRB_STACK:  cnt_q <= VECTOR_ST - 5'h01;
              default:    cnt_q <= HALF_ST - 5'h01;
            endcase
          end
        end
        IRB_FETCH2: begin
          state_q <= IRB_IDLE;
          start_q <= 1'b1;
        end
        default: begin
          state_q <= IRB_IDLE;
        end
      endcase
    end
  end

  assign ext_flag_o      = ext_flag_q;
  assign key_flag_o      = key_flag_q;
  assign i_mask_o        = i_mask_q;
  assign ui_mask_o       = ui_mask_q;
  assign state_o         = state_q;
  assign accept_o        = accept_q;
  assign src_o           = src_q;
  assign save_next_pc_o  = save_next_q;
  assign wait_states_o   = wait_q;
  assign handler_start_o = start_q;
endmodule

// >>> irb_pkg.sv
/*
  Shared constants for the interrupt response sequencer and the address-break
  comparator. Assumes one 50 MHz clock where one CPU state is one clock cycle.
*/
package irb_pkg;
  localparam int unsigned CLK_MHZ       = 50;
  localparam int unsigned STATE_NS      = 20;
  localparam int unsigned STATE_CYC     = (STATE_NS * CLK_MHZ + 999) / 1000;
  // stage lengths in states
  localparam logic [4:0]  PRIO_EXT_ST   = 5'h03;
  localparam logic [4:0]  PRIO_INT_ST   = 5'h02;
  localparam logic [4:0]  WAIT_MAX_ST   = 5'h15;
  localparam logic [4:0]  STACK_ST      = 5'h02;
  localparam logic [4:0]  VECTOR_ST     = 5'h02;
  localparam logic [4:0]  HALF_ST       = 5'h01;
  localparam int unsigned MASK_DLY_ST   = 2;
  // address fields
  localparam int unsigned ADDR_W        = 24;
  localparam int unsigned CMP_LSB       = 1;
  localparam int unsigned NORM_MSB      = 15;
  localparam logic [23:0] BAR_RST       = 24'h000000;
  // source index layout of the request vector, lower index wins
  localparam int unsigned NUM_EXT       = 16;
  localparam int unsigned IDX_NMI       = 0;
  localparam int unsigned IDX_BRK       = 1;
  localparam int unsigned IDX_EXT0      = 2;
  localparam int unsigned IDX_KEY       = IDX_EXT0 + NUM_EXT;
  localparam int unsigned IDX_INT0      = IDX_KEY + 1;
  localparam logic [4:0]  SRC_NONE      = 5'h1F;

  typedef enum logic [3:0] {
    IRB_IDLE   = 4'h0,
    IRB_PRIO   = 4'h1,
    IRB_WAIT   = 4'h2,
    IRB_FETCH1 = 4'h3,
    IRB_INT1   = 4'h4,
    IRB_STACK  = 4'h5,
    IRB_VECTOR = 4'h6,
    IRB_INT2   = 4'h7,
    IRB_FETCH2 = 4'h8
  } irb_state_t;
endpackage

// >>> irb_brk_cmp.sv
/*
  Address-break comparator with its break address, enable bit and match flag.
  Assumes the prefetch strobe and address come from logic on the same clock.
*/
module irb_brk_cmp (
  input  wire logic                         mclk_i,
  input  wire logic                         arst_n_i,
  input  wire logic                         bar_wr_i,
  input  wire logic [irb_pkg::ADDR_W-1:0]   bar_data_i,
  input  wire logic                         bie_wr_i,
  input  wire logic                         bie_data_i,
  input  wire logic                         cmf_clr_i,
  input  wire logic                         normal_mode_i,
  input  wire logic                         prefetch_i,
  input  wire logic [irb_pkg::ADDR_W-1:0]   fetch_addr_i,
  output logic [irb_pkg::ADDR_W-1:0]        bar_o,
  output logic                              bie_o,
  output logic                              cmf_o,
  output logic                              brk_req_o
);
  import irb_pkg::*;

  logic [ADDR_W-1:0] bar_q;
  logic              bie_q;
  logic              cmf_q;
  logic              brk_req_q;
  logic              hit;
  logic              hi_ok;

  // bit 0 never compared; high byte skipped in normal mode
  assign hi_ok = normal_mode_i
               || (fetch_addr_i[ADDR_W-1:NORM_MSB+1] == bar_q[ADDR_W-1:NORM_MSB+1]);
  assign hit   = bie_q && prefetch_i && hi_ok
               && (fetch_addr_i[NORM_MSB:CMP_LSB] == bar_q[NORM_MSB:CMP_LSB]);

  // break address and enable bit
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bar_q <= BAR_RST;
      bie_q <= 1'b0;
    end else begin
      if (bar_wr_i) begin
        bar_q <= {bar_data_i[ADDR_W-1:CMP_LSB], 1'b0};
      end
      if (bie_wr_i) begin
        bie_q <= bie_data_i;
      end
    end
  end

  // match flag and one-cycle request, set beats clear
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmf_q     <= 1'b0;
      brk_req_q <= 1'b0;
    end else begin
      brk_req_q <= hit;
      if (hit) begin
        cmf_q <= 1'b1;
      end else if (cmf_clr_i) begin
        cmf_q <= 1'b0;
      end
    end
  end

  assign bar_o     = bar_q;
  assign bie_o     = bie_q;
  assign cmf_o     = cmf_q;
  assign brk_req_o = brk_req_q;
endmodule

// >>> irb_cpu_model.sv
/*
  Behavioural CPU core: fixed-length instructions, each ending with the prefetch of the next.
  Assumes the sequencer's clock and reset; jump_i redirects the prefetch at the next instruction end.
*/
module irb_cpu_model (
  input  wire logic                       mclk_i,
  input  wire logic                       arst_n_i,
  input  wire logic [4:0]                 len_i,
  input  wire logic                       jump_i,
  input  wire logic [irb_pkg::ADDR_W-1:0] jump_addr_i,
  output logic                            insn_end_o,
  output logic                            prefetch_o,
  output logic [irb_pkg::ADDR_W-1:0]      fetch_addr_o
);
  import irb_pkg::*;
  logic [4:0]        cnt_q;
  logic [ADDR_W-1:0] pc_q;
  // instruction timing, prefetch at each end, data traffic on the address bus otherwise
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= 5'h00;
      pc_q <= 24'h000000;
      insn_end_o <= 1'h0;
      prefetch_o <= 1'h0;
      fetch_addr_o <= 24'h000000;
    end else if (cnt_q + 5'h01 >= len_i) begin
      cnt_q <= 5'h00;
      insn_end_o <= 1'h1;
      prefetch_o <= 1'h1;
      fetch_addr_o <= jump_i ? jump_addr_i : pc_q;
      pc_q <= (jump_i ? jump_addr_i : pc_q) + 24'h000002;
    end else begin
      cnt_q <= cnt_q + 5'h01;
      insn_end_o <= 1'h0;
      prefetch_o <= 1'h0;
      fetch_addr_o <= ~fetch_addr_o; // data access, strobe stays low
    end
  end
endmodule

// >>> irb_intc_sva.sv
/*
  Port checker for the interrupt sequencer and address-break comparator.
  Assumes it is bound to irb_intc and sees only that module's ports.
*/
module irb_intc_sva
  import irb_pkg::*;
(
  input wire logic                       mclk_i,
  input wire logic                       arst_n_i,
  input wire logic                       insn_end_i,
  input wire logic                       ccr_insn_end_i,
  input wire logic                       ccr_i_bit_i,
  input wire logic                       ccr_ui_bit_i,
  input wire logic                       blk_byte_busy_i,
  input wire logic                       blk_word_gap_i,
  input wire logic                       normal_mode_i,
  input wire logic                       prefetch_i,
  input wire logic [irb_pkg::ADDR_W-1:0] fetch_addr_i,
  input wire logic [irb_pkg::ADDR_W-1:0] bar_o,
  input wire logic                       bie_o,
  input wire logic                       cmf_o,
  input wire logic                       i_mask_o,
  input wire logic                       ui_mask_o,
  input wire logic [3:0]                 state_o,
  input wire logic                       accept_o,
  input wire logic [4:0]                 src_o,
  input wire logic                       handler_start_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  // break comparator
  chk_brk_full_match: assert property (
    prefetch_i && bie_o && !normal_mode_i && fetch_addr_i[23:1] == bar_o[23:1] |=> cmf_o)
    else $error("full address match left the flag clear");
  chk_brk_norm_match: assert property (
    prefetch_i && bie_o && normal_mode_i && fetch_addr_i[15:1] == bar_o[15:1] |=> cmf_o)
    else $error("normal mode match left the flag clear");
  chk_brk_cause: assert property (
    $rose(cmf_o) |-> $past(bie_o) && $past(prefetch_i))
    else $error("flag rose without an enabled prefetch");
  // priority decision lengths
  chk_prio_ext_len: assert property (
    accept_o && src_o != 5'h01 && src_o <= 5'h12
    |-> $past(state_o) == 4'h1 && $past(state_o, 2) == 4'h1 && $past(state_o, 3) == 4'h1)
    else $error("external acceptance under three states");
  chk_prio_brk_len: assert property (
    accept_o && src_o == 5'h01 |-> $past(state_o) == 4'h1 && $past(state_o, 2) == 4'h1)
    else $error("break acceptance under two states");
  // waiting for the running instruction, then the entry stages
  chk_wait_hold: assert property (
    state_o == 4'h2 && !insn_end_i && !blk_word_gap_i |=> state_o == 4'h2)
    else $error("entry began before the instruction ended");
  chk_wait_end: assert property (
    state_o == 4'h2 && insn_end_i |=> state_o == 4'h3)
    else $error("entry did not follow the instruction end");
  chk_entry_order: assert property (
    state_o == 4'h3 |=> state_o == 4'h4 ##1 state_o == 4'h5 [*2] ##1 state_o == 4'h6 [*2]
    ##1 state_o == 4'h7 ##1 state_o == 4'h8 ##1 handler_start_o)
    else $error("entry stages out of order or length");
  // acceptance hold-offs and masking
  chk_byte_block: assert property (
    blk_byte_busy_i |=> !accept_o)
    else $error("accepted during byte block move");
  chk_ccr_holdoff: assert property (
    ccr_insn_end_i ##1 !insn_end_i |=> !accept_o)
    else $error("accepted before the next instruction ran");
  chk_mask_delay: assert property (
    ccr_insn_end_i |-> ##3 i_mask_o == ccr_i_bit_i && ui_mask_o == ccr_ui_bit_i)
    else $error("mask bits not in effect two states later");
  chk_mask_sources: assert property (
    accept_o && $past(i_mask_o) |-> src_o <= 5'h01)
    else $error("maskable source accepted while masked");
endmodule

bind irb_intc irb_intc_sva u_sva (.mclk_i, .arst_n_i, .insn_end_i, .ccr_insn_end_i, .ccr_i_bit_i,
  .ccr_ui_bit_i, .blk_byte_busy_i, .blk_word_gap_i, .normal_mode_i, .prefetch_i, .fetch_addr_i,
  .bar_o, .bie_o, .cmf_o, .i_mask_o, .ui_mask_o, .state_o, .accept_o, .src_o, .handler_start_o);

// >>> tb_top.sv
/*
  Self-checking bench for irb_intc with a behavioural CPU core on its far side.
  Assumes a 50 MHz clock and inputs driven 2 ns after each rising edge.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import irb_pkg::*;
  int          mismatches = 0, total_checks = 0, acc_cnt = 0;
  logic        mclk_i = '0, arst_n_i = '0, ccr_insn_end_i = '0, ccr_i_bit_i = '0, ccr_ui_bit_i = '0;
  logic        blk_byte_busy_i = '0, blk_word_busy_i = '0, blk_word_gap_i = '0, normal_mode_i = '0;
  logic        bar_wr_i = '0, bie_wr_i = '0, bie_data_i = '0, cmf_clr_i = '0, nmi_n_i = '1, key_n_i = '1;
  logic        key_en_i = '0, key_flag_clr_i = '0, vec_mode_i = '0, jump_i = '0, gap_en = '0;
  logic [23:0] bar_data_i = '0, jump_addr_i = '0, bar_o, fetch_addr_i;
  logic [15:0] ext_irq_n_i = '1, ext_en_i = '0, ext_flag_clr_i = '0, ext_flag_o;
  logic [7:0]  int_req_i = '0, int_en_i = '0;
  logic [4:0]  len_i = 5'h04, src_o, wait_states_o;
  logic [3:0]  state_o;
  logic [1:0]  cyc_q = 2'h0;
  logic        bie_o, cmf_o, key_flag_o, i_mask_o, ui_mask_o, accept_o, save_next_pc_o;
  logic        handler_start_o, insn_end_i, prefetch_i;

  irb_intc dut (.mclk_i, .arst_n_i, .insn_end_i, .ccr_insn_end_i, .ccr_i_bit_i, .ccr_ui_bit_i,
    .blk_byte_busy_i, .blk_word_busy_i, .blk_word_gap_i, .normal_mode_i, .prefetch_i, .fetch_addr_i,
    .bar_wr_i, .bar_data_i, .bie_wr_i, .bie_data_i, .cmf_clr_i, .nmi_n_i, .ext_irq_n_i, .ext_en_i,
    .ext_flag_clr_i, .key_n_i, .key_en_i, .key_flag_clr_i, .vec_mode_i, .int_req_i, .int_en_i,
    .bar_o, .bie_o, .cmf_o, .ext_flag_o, .key_flag_o, .i_mask_o, .ui_mask_o, .state_o, .accept_o,
    .src_o, .save_next_pc_o, .wait_states_o, .handler_start_o);
  irb_cpu_model u_cpu (.mclk_i, .arst_n_i, .len_i, .jump_i, .jump_addr_i, .insn_end_o(insn_end_i),
    .prefetch_o(prefetch_i), .fetch_addr_o(fetch_addr_i));

  // clock
  always #10 mclk_i = ~mclk_i;
  // transfer gaps of the word block move, acceptance count
  always @(posedge mclk_i) begin
    cyc_q <= cyc_q + 2'h1;
    blk_word_gap_i <= gap_en && cyc_q == 2'h0;
    if (accept_o === 1'h1) acc_cnt <= acc_cnt + 1;
  end

  function automatic logic brk_hit(input logic [23:0] b, input logic [23:0] a, input logic nm);
    return nm ? a[15:1] == b[15:1] : a[23:1] == b[23:1];
  endfunction
  function automatic logic [4:0] ext_src(input int a, input int b);
    return 5'(IDX_EXT0 + (a < b ? a : b));
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    #2;
  endtask
  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // one prefetch of a, then the next one far away so the walk never reaches the break address
  task automatic jump(input logic [23:0] a, input logic [23:0] away);
    jump_addr_i = a;
    jump_i = 1'h1;
    step(int'(len_i));
    jump_addr_i = away;
    step(int'(len_i));
    jump_i = 1'h0;
  endtask
  task automatic set_mask(input logic v);
    ccr_i_bit_i = v;
    ccr_ui_bit_i = v;
    ccr_insn_end_i = 1'h1;
    step(1);
    ccr_insn_end_i = 1'h0;
    step(4);
    chk("i_mask", 24'(v), 24'(i_mask_o));
    chk("ui_mask", 24'(v), 24'(ui_mask_o));
  endtask
  // wait for the handler start, check the source, then release pins and clear flags
  task automatic serve(input logic [4:0] src, input logic save);
    int n;
    n = 0;
    while (handler_start_o !== 1'h1 && n < 200) begin
      step(1);
      n++;
    end
    if (n == 200) begin
      mismatches++;
      $display("unexpected handler_start: expected 1, seen 0");
      report_and_stop();
    end
    chk("src", 24'(src), 24'(src_o));
    chk("save_next_pc", 24'(save), 24'(save_next_pc_o));
    chk("wait_in_range", 24'h000001, 24'(wait_states_o >= 5'h01 && wait_states_o <= 5'h15));
    nmi_n_i = 1'h1;
    ext_irq_n_i = '1;
    key_n_i = 1'h1;
    step(4);
    chk("i_mask", 24'h000001, 24'(i_mask_o));
    ext_flag_clr_i = '1;
    key_flag_clr_i = 1'h1;
    cmf_clr_i = 1'h1;
    step(1);
    ext_flag_clr_i = '0;
    key_flag_clr_i = 1'h0;
    cmf_clr_i = 1'h0;
    step(2);
    $display("test done: source %0d", src);
  endtask

  initial begin
    logic [23:0] bar, addr;
    logic        nm, hit;
    int          a, b, k;
    int          ks[4];
    void'($urandom(91562));
    ks = '{0, 1, 16, 23};
    step(10);
    arst_n_i = 1'h1;
    step(1);
    chk("src", 24'(SRC_NONE), 24'(src_o));
    chk("state", 24'h000000, 24'(state_o));
    step(4);
    ext_flag_clr_i = '1;
    step(1);
    ext_flag_clr_i = '0;
    chk("ext_flag", 24'h000000, 24'(ext_flag_o));
    // break address written with bit 0 set, enable still clear
    bar = 24'($urandom) & 24'hFFFFFE;
    bar_data_i = bar | 24'h000001;
    bar_wr_i = 1'h1;
    step(1);
    bar_wr_i = 1'h0;
    chk("bar", bar, bar_o);
    jump(bar, bar ^ 24'h008000);
    step(2);
    chk("cmf", 24'h000000, 24'(cmf_o));
    bie_data_i = 1'h1;
    bie_wr_i = 1'h1;
    step(1);
    bie_wr_i = 1'h0;
    chk("bie", 24'h000001, 24'(bie_o));
    set_mask(1'h1);
    // one address bit flipped at a time, both address modes
    for (int i = 0; i < 8; i++) begin
      k = i < 4 ? ks[i] : $urandom_range(23, 0);
      nm = 1'($urandom_range(1, 0));
      normal_mode_i = nm;
      addr = bar ^ (24'h000001 << k);
      hit = brk_hit(bar, addr, nm);
      jump(addr, bar ^ 24'h008000);
      step(2);
      chk("cmf", 24'(hit), 24'(cmf_o));
      if (hit) serve(5'(IDX_BRK), 1'h0);
    end
    normal_mode_i = 1'h0;
    ext_en_i = '1;
    // two external pins together, the last round with the non-maskable pin as well
    for (int i = 0; i < 4; i++) begin
      a = $urandom_range(15, 0);
      b = $urandom_range(15, 0);
      set_mask(1'h0);
      ext_irq_n_i[a] = 1'h0;
      ext_irq_n_i[b] = 1'h0;
      nmi_n_i = i != 3;
      serve(i == 3 ? 5'(IDX_NMI) : ext_src(a, b), 1'h0);
    end
    // byte block move holds everything off
    blk_byte_busy_i = 1'h1;
    set_mask(1'h0);
    ext_irq_n_i[a] = 1'h0;
    k = acc_cnt;
    step(40);
    chk("accepts", 24'(k), 24'(acc_cnt));
    blk_byte_busy_i = 1'h0;
    serve(ext_src(a, a), 1'h0);
    // word block move is interrupted between transfers
    len_i = 5'h1F;
    gap_en = 1'h1;
    blk_word_busy_i = 1'h1;
    set_mask(1'h0);
    ext_irq_n_i[a] = 1'h0;
    serve(ext_src(a, a), 1'h1);
    gap_en = 1'h0;
    blk_word_busy_i = 1'h0;
    len_i = 5'h04;
    // key pin low while the vector mode switches on
    key_en_i = 1'h1;
    set_mask(1'h0);
    key_n_i = 1'h0;
    step(6);
    chk("key_flag", 24'h000000, 24'(key_flag_o));
    vec_mode_i = 1'h1;
    serve(5'(IDX_KEY), 1'h0);
    report_and_stop();
  end
endmodule
